//--- char_lcd_host_interface.sv
// Purpose: Host front end of a character display controller
// Assumes: Host obeys the busy indication before each instruction
// Notes: Serial logic runs on the serial clock pin as its own domain
`timescale 1ns/10ps

// How it works
// [RULE1] Strap high selects parallel, low serial
// [RULE2] Serial frame: chip select, clock, data
// [RULE3] Eight data lines, bit 7 busy on status
// [RULE4] Command and data holding registers, 8 bits
// [RULE5] Command register is write only
// [RULE6] Select low, write: execute instruction
// [RULE7] Select low, read: busy and counter
// [RULE8] Select high, write: store at address
// [RULE9] Select high, read: return fetched byte
// [RULE10] Address set prefetches RAM into data register
// [RULE11] Busy high during operation, refuse instructions
// [RULE12] Host polls busy before each instruction
// [RULE13] Address set loads the address counter
// [RULE14] Counter steps by one after access
// [RULE15] Text RAM holds eighty character codes
// [RULE16] Lines map to 00-0F and 40-4F; text RAM takes 00-27 and 40-67, the scan shows 00-0F of each line
// [RULE17] Pattern ROM gives 5x8 or 5x10 dots
// [RULE18] Codes 0x-0F select eight user glyphs
// [RULE19] Glyph row select, five pixel bits
// [RULE20] Four-bit width: two nibble transfers
// [RULE21] Step direction follows entry mode
// [RULE22] Host discards first read without address set
// [RULE23] Host sets select first; capture on fall
// [RULE24] Three-wire frame carries the select bit
// [RULE25] Reset pin low: busy, no instructions
module char_lcd_host_interface #(
	parameter int CLEAR_CYC = char_lcd_pkg::CLEAR_CYCLES
) (
	// Clocks and reset
	input wire logic core_clk_i,
	input wire logic reset_i,
	input wire logic serial_clk_i,
	// Straps and control pins
	input wire logic rst_n_i,
	input wire logic interface_select_strap_i,
	input wire logic three_wire_select_i,
	input wire logic register_select_i,
	input wire logic read_write_i,
	input wire logic enable_i,
	// Data lines
	input wire logic [7:0] parallel_data_lines_i,
	output logic [7:0] parallel_data_lines_o,
	output logic parallel_data_lines_oe_o,
	// Display scan side
	input wire logic scan_line_i,
	input wire logic [3:0] scan_col_i,
	input wire logic [3:0] scan_row_i,
	input wire logic font_tall_i,
	output logic [4:0] scan_pixels_o,
	output logic display_on_o,
	output logic two_line_o,
	output logic internal_busy_indication_o
);

	typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_CLEAR} state_t;

	// ---------------------------------------------------------------
	// Serial clock domain
	// ---------------------------------------------------------------
	logic tw_s1_reg;
	logic tw_s2_reg;
	logic [3:0] bit_cnt_reg;
	logic [7:0] shift_reg;
	logic [7:0] ser_byte_reg;
	logic ser_rs_reg;
	logic ser_tog_reg;
	logic ser_clr;
	logic [3:0] frame_len;
	logic frame_end;

	// Chip select high ends a frame even with the clock stopped
	assign ser_clr = reset_i | parallel_data_lines_i[char_lcd_pkg::SER_CS_BIT];
	assign frame_len = tw_s2_reg ? char_lcd_pkg::FRAME_BITS_3W
		: char_lcd_pkg::FRAME_BITS_4W;
	assign frame_end = (bit_cnt_reg == frame_len - 4'h1);

	always_ff @(posedge serial_clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			tw_s1_reg <= 1'b0;
			tw_s2_reg <= 1'b0;
		end
		else
		begin
			tw_s1_reg <= three_wire_select_i;
			tw_s2_reg <= tw_s1_reg;
		end
	end

	always_ff @(posedge serial_clk_i or posedge ser_clr)
	begin
		if (ser_clr)
		begin
			bit_cnt_reg <= 4'h0;
			shift_reg <= 8'h00;
		end
		else
		begin
			shift_reg <= {shift_reg[6:0],
				parallel_data_lines_i[char_lcd_pkg::SER_SID_BIT]}; // RULE2
			bit_cnt_reg <= frame_end ? 4'h0 : bit_cnt_reg + 4'h1;
		end
	end

	// Held byte stays stable until the next frame ends
	always_ff @(posedge serial_clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			ser_byte_reg <= 8'h00;
			ser_rs_reg <= 1'b0;
			ser_tog_reg <= 1'b0;
		end
		else if (frame_end &&
			!parallel_data_lines_i[char_lcd_pkg::SER_CS_BIT])
		begin
			ser_byte_reg <= {shift_reg[6:0],
				parallel_data_lines_i[char_lcd_pkg::SER_SID_BIT]};
			ser_rs_reg <= tw_s2_reg ? shift_reg[7] : register_select_i; // RULE24
			ser_tog_reg <= ~ser_tog_reg;
		end
	end

	// ---------------------------------------------------------------
	// Pin synchronisers
	// ---------------------------------------------------------------
	logic [char_lcd_pkg::PIN_W-1:0] pin_raw;
	logic [char_lcd_pkg::PIN_W-1:0] pin_s1_reg;
	logic [char_lcd_pkg::PIN_W-1:0] pin_s2_reg;
	logic en_s3_reg;
	logic tog_s1_reg;
	logic tog_s2_reg;
	logic tog_s3_reg;

	assign pin_raw = {rst_n_i, interface_select_strap_i,
		three_wire_select_i, register_select_i, read_write_i,
		enable_i, parallel_data_lines_i};

	always_ff @(posedge core_clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			pin_s1_reg <= '0;
			pin_s2_reg <= '0;
			en_s3_reg <= 1'b0;
			tog_s1_reg <= 1'b0;
			tog_s2_reg <= 1'b0;
			tog_s3_reg <= 1'b0;
		end
		else
		begin
			pin_s1_reg <= pin_raw;
			pin_s2_reg <= pin_s1_reg;
			en_s3_reg <= pin_s2_reg[char_lcd_pkg::PIN_EN];
			tog_s1_reg <= ser_tog_reg;
			tog_s2_reg <= tog_s1_reg;
			tog_s3_reg <= tog_s2_reg;
		end
	end

	logic interface_select_strap;
	logic rst_ok;
	logic rs_s;
	logic rw_s;
	logic [7:0] db_s;
	logic par_fall;
	logic ser_evt;

	assign interface_select_strap = pin_s2_reg[char_lcd_pkg::PIN_STRAP];
	assign rst_ok = pin_s2_reg[char_lcd_pkg::PIN_RST_N];
	assign rs_s = pin_s2_reg[char_lcd_pkg::PIN_RS];
	assign rw_s = pin_s2_reg[char_lcd_pkg::PIN_RW];
	assign db_s = pin_s2_reg[7:0];
	assign par_fall = interface_select_strap && en_s3_reg &&
		!pin_s2_reg[char_lcd_pkg::PIN_EN]; // RULE23
	assign ser_evt = !interface_select_strap && (tog_s2_reg ^ tog_s3_reg); // RULE1

	// ---------------------------------------------------------------
	// Request assembly
	// ---------------------------------------------------------------
	logic wide_bus_reg;
	logic nib_phase_reg;
	logic [3:0] nib_hi_reg;
	logic req_valid;
	logic req_rs;
	logic req_rw;
	logic [7:0] req_byte;

	always_comb
	begin
		req_valid = 1'b0;
		req_rs = 1'b0;
		req_rw = 1'b0;
		req_byte = 8'h00;
		if (ser_evt)
		begin
			req_valid = 1'b1;
			req_rs = ser_rs_reg;
			req_byte = ser_byte_reg;
		end
		else if (par_fall)
		begin
			req_rs = rs_s;
			req_rw = rw_s;
			req_valid = wide_bus_reg || nib_phase_reg; // RULE20
			req_byte = wide_bus_reg ? db_s : {nib_hi_reg, db_s[7:4]};
		end
	end

	// High nibble first, then low nibble
	always_ff @(posedge core_clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			nib_phase_reg <= 1'b0;
			nib_hi_reg <= 4'h0;
		end
		else if (wide_bus_reg || !rst_ok)
			nib_phase_reg <= 1'b0;
		else if (par_fall)
		begin
			nib_phase_reg <= ~nib_phase_reg; // RULE20
			nib_hi_reg <= db_s[7:4];
		end
	end

	// ---------------------------------------------------------------
	// Control state
	// ---------------------------------------------------------------
	state_t state_reg;
	logic [15:0] cnt_reg;
	logic [6:0] clr_idx_reg;
	logic can_run;
	logic instr_acc;
	logic wdat_acc;
	logic rdat_acc;

	assign can_run = (state_reg == ST_IDLE) && rst_ok; // RULE25
	assign instr_acc = req_valid && !req_rs && !req_rw && can_run; // RULE6
	assign wdat_acc = req_valid && req_rs && !req_rw && can_run; // RULE8
	assign rdat_acc = req_valid && req_rs && req_rw && can_run; // RULE9

	always_ff @(posedge core_clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			state_reg <= ST_IDLE;
			cnt_reg <= 16'h0000;
			clr_idx_reg <= 7'h00;
		end
		else
		begin
			unique case (state_reg)
				ST_IDLE:
				begin
					clr_idx_reg <= 7'h00;
					if (instr_acc && req_byte == char_lcd_pkg::CMD_CLEAR)
					begin
						state_reg <= ST_CLEAR;
						cnt_reg <= 16'(CLEAR_CYC - 1);
					end
					else if (instr_acc || wdat_acc || rdat_acc)
					begin
						state_reg <= ST_EXEC; // RULE11
						cnt_reg <= 16'(char_lcd_pkg::EXEC_CYCLES - 1);
					end
				end
				ST_EXEC:
				begin
					cnt_reg <= cnt_reg - 16'h0001;
					if (cnt_reg == 16'h0000)
						state_reg <= ST_IDLE;
				end
				ST_CLEAR:
				begin
					cnt_reg <= cnt_reg - 16'h0001;
					if (clr_idx_reg != 7'(char_lcd_pkg::TEXT_DEPTH))
						clr_idx_reg <= clr_idx_reg + 7'h01;
					if (cnt_reg == 16'h0000)
						state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk_i or posedge reset_i)
	begin
		if (reset_i)
			internal_busy_indication_o <= 1'b1;
		else
			internal_busy_indication_o <= (state_reg != ST_IDLE) ||
				instr_acc || wdat_acc || rdat_acc || !rst_ok; // RULE11
	end

	// ---------------------------------------------------------------
	// Registers and address counter
	// ---------------------------------------------------------------
	logic [7:0] command_holding_register_reg;
	logic [7:0] ram_data_holding_register_reg;
	logic [6:0] ac_reg;
	logic glyph_sel_reg;
	logic inc_reg;
	logic ext_reg;
	logic pf_reg;
	logic [6:0] ac_step;
	logic [7:0] ram_rd_byte;

	assign ac_step = inc_reg ? ac_reg + 7'h01 : ac_reg - 7'h01; // RULE21

	// Write only: nothing on the read path selects this register
	always_ff @(posedge core_clk_i or posedge reset_i)
	begin
		if (reset_i)
			command_holding_register_reg <= 8'h00;
		else if (instr_acc)
			command_holding_register_reg <= req_byte; // RULE4 RULE5
	end

	always_ff @(posedge core_clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			ac_reg <= 7'h00;
			glyph_sel_reg <= 1'b0;
			inc_reg <= char_lcd_pkg::INC_RESET;
			ext_reg <= char_lcd_pkg::EXT_RESET;
			wide_bus_reg <= char_lcd_pkg::WIDE_BUS_RESET;
			display_on_o <= char_lcd_pkg::DISP_ON_RESET;
			two_line_o <= char_lcd_pkg::TWO_LINE_RESET;
			pf_reg <= 1'b0;
		end
		else if (instr_acc)
		begin
			pf_reg <= 1'b0;
			unique casez (req_byte)
				8'b0000_0001:
				begin
					ac_reg <= 7'h00;
					glyph_sel_reg <= 1'b0;
					inc_reg <= 1'b1;
				end
				8'b0000_001?:
				begin
					ac_reg <= 7'h00;
					glyph_sel_reg <= 1'b0;
				end
				8'b0000_01??:
					if (!ext_reg)
						inc_reg <= req_byte[1];
				8'b0000_1???:
					display_on_o <= req_byte[2];
				8'b0001_????:
					if (!req_byte[3])
					begin
						ac_reg <= req_byte[2] ? ac_reg + 7'h01
							: ac_reg - 7'h01;
						pf_reg <= !glyph_sel_reg;
					end
				8'b001?_????:
				begin
					wide_bus_reg <= req_byte[4];
					two_line_o <= req_byte[3];
					ext_reg <= req_byte[2];
				end
				8'b01??_????:
					if (!ext_reg)
					begin
						ac_reg <= {1'b0, req_byte[5:0]}; // RULE13
						glyph_sel_reg <= 1'b1;
						pf_reg <= 1'b1; // RULE10
					end
				8'b1???_????:
					if (!ext_reg)
					begin
						ac_reg <= req_byte[6:0]; // RULE13
						glyph_sel_reg <= 1'b0;
						pf_reg <= 1'b1; // RULE10
					end
				default:
					pf_reg <= 1'b0;
			endcase
		end
		else if (wdat_acc || rdat_acc)
		begin
			ac_reg <= ac_step; // RULE14
			pf_reg <= rdat_acc;
		end
		else
			pf_reg <= 1'b0;
	end

	// Fetch lags the counter by a cycle; the host is far slower
	always_ff @(posedge core_clk_i or posedge reset_i)
	begin
		if (reset_i)
			ram_data_holding_register_reg <= 8'h00;
		else if (pf_reg)
			ram_data_holding_register_reg <= ram_rd_byte; // RULE10
	end

	// ---------------------------------------------------------------
	// Text and glyph memories
	// ---------------------------------------------------------------
	logic [7:0] text_ram [char_lcd_pkg::TEXT_DEPTH];
	logic [7:0] glyph_ram [char_lcd_pkg::GLYPH_DEPTH];
	logic [6:0] text_idx;
	logic text_ok;

	// Line two starts at 40 hex; other addresses hold nothing
	assign text_ok = ac_reg[5:0] < 6'(char_lcd_pkg::LINE_LEN);
	assign text_idx = ac_reg[6] ? char_lcd_pkg::LINE_LEN + {1'b0, ac_reg[5:0]}
		: {1'b0, ac_reg[5:0]}; // RULE16
	assign ram_rd_byte = glyph_sel_reg ? glyph_ram[ac_reg[5:0]]
		: (text_ok ? text_ram[text_idx] : 8'h00);

	always_ff @(posedge core_clk_i)
	begin
		if (state_reg == ST_CLEAR &&
			clr_idx_reg != 7'(char_lcd_pkg::TEXT_DEPTH))
			text_ram[clr_idx_reg] <= char_lcd_pkg::SPACE_CODE; // RULE15
		else if (wdat_acc && glyph_sel_reg)
			glyph_ram[ac_reg[5:0]] <= req_byte; // RULE19
		else if (wdat_acc && text_ok)
			text_ram[text_idx] <= req_byte; // RULE8
	end

	// ---------------------------------------------------------------
	// Host read path
	// ---------------------------------------------------------------
	logic [7:0] rd_val;

	assign rd_val = rs_s ? ram_data_holding_register_reg // RULE9
		: {internal_busy_indication_o, ac_reg}; // RULE7

	always_ff @(posedge core_clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			parallel_data_lines_o <= 8'h00;
			parallel_data_lines_oe_o <= 1'b0;
		end
		else
		begin
			parallel_data_lines_oe_o <= interface_select_strap && rw_s && rst_ok &&
				pin_s2_reg[char_lcd_pkg::PIN_EN]; // RULE3
			if (wide_bus_reg)
				parallel_data_lines_o <= rd_val;
			else
				parallel_data_lines_o <= nib_phase_reg
					? {rd_val[3:0], 4'h0} : {rd_val[7:4], 4'h0};
		end
	end

	// ---------------------------------------------------------------
	// Pattern lookup for the display scan
	// ---------------------------------------------------------------
	// Stand-in font: a real part loads its character set here
	function automatic logic [4:0] glyph_rom(input logic [7:0] code,
		input logic [3:0] row);
		glyph_rom = (row == 4'h0 || row == 4'h6) ? code[4:0]
			: {code[7], 3'h0, code[0]};
	endfunction : glyph_rom

	logic [6:0] scan_idx;
	logic [7:0] scan_code;
	logic [3:0] row_limit;

	assign scan_idx = scan_line_i ? char_lcd_pkg::LINE_LEN + {3'h0, scan_col_i}
		: {3'h0, scan_col_i}; // RULE16
	assign scan_code = text_ram[scan_idx];
	assign row_limit = font_tall_i ? 4'hA : 4'h8; // RULE17

	always_ff @(posedge core_clk_i or posedge reset_i)
	begin
		if (reset_i)
			scan_pixels_o <= 5'h00;
		else if (scan_row_i >= row_limit)
			scan_pixels_o <= 5'h00;
		else if (scan_code[7:4] == 4'h0)
			scan_pixels_o <= scan_row_i[3] ? 5'h00
				: glyph_ram[{scan_code[2:0], scan_row_i[2:0]}][4:0]; // RULE18
		else
			scan_pixels_o <= glyph_rom(scan_code, scan_row_i); // RULE17
	end

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	property p_reset_busy;
		@(posedge core_clk_i) disable iff (reset_i)
		!rst_ok |=> internal_busy_indication_o && !instr_acc;
	endproperty
	a_reset_busy: assert property (p_reset_busy) // RULE25
		else $error("busy low while reset pin held");

	property p_busy_hold;
		@(posedge core_clk_i) disable iff (reset_i)
		(instr_acc && req_byte != char_lcd_pkg::CMD_CLEAR)
			|=> internal_busy_indication_o [*8];
	endproperty
	a_busy_hold: assert property (p_busy_hold) // RULE11
		else $error("busy dropped too early after instruction");

	property p_refuse;
		@(posedge core_clk_i) disable iff (reset_i)
		(req_valid && state_reg != ST_IDLE)
			|=> $stable(command_holding_register_reg);
	endproperty
	a_refuse: assert property (p_refuse) // RULE11
		else $error("instruction taken while busy");

	property p_ac_load;
		@(posedge core_clk_i) disable iff (reset_i)
		(instr_acc && req_byte[7] && !ext_reg)
			|=> ac_reg == $past(req_byte[6:0]) && !glyph_sel_reg;
	endproperty
	a_ac_load: assert property (p_ac_load) // RULE13
		else $error("address counter not loaded");

	property p_step;
		@(posedge core_clk_i) disable iff (reset_i)
		(wdat_acc || rdat_acc) |=>
			ac_reg == ($past(inc_reg) ? $past(ac_reg) + 7'h01
			: $past(ac_reg) - 7'h01);
	endproperty
	a_step: assert property (p_step) // RULE14
		else $error("address counter did not step");

	property p_prefetch;
		@(posedge core_clk_i) disable iff (reset_i)
		(instr_acc && req_byte[7] && !ext_reg) |=> pf_reg
			##1 ram_data_holding_register_reg == $past(ram_rd_byte);
	endproperty
	a_prefetch: assert property (p_prefetch) // RULE10
		else $error("data register not fetched after address set");

	property p_write;
		@(posedge core_clk_i) disable iff (reset_i)
		(wdat_acc && !glyph_sel_reg && text_ok)
			|=> text_ram[$past(text_idx)] == $past(req_byte);
	endproperty
	a_write: assert property (p_write) // RULE8
		else $error("text write lost");

	property p_serial_quiet;
		@(posedge core_clk_i) disable iff (reset_i)
		!interface_select_strap |=> !parallel_data_lines_oe_o;
	endproperty
	a_serial_quiet: assert property (p_serial_quiet) // RULE1
		else $error("data lines driven in serial mode");

	property p_status;
		@(posedge core_clk_i) disable iff (reset_i)
		(wide_bus_reg && !rs_s) |=>
			parallel_data_lines_o ==
			{$past(internal_busy_indication_o), $past(ac_reg)};
	endproperty
	a_status: assert property (p_status) // RULE7
		else $error("status byte wrong");

endmodule : char_lcd_host_interface

//--- char_lcd_pkg.sv
// Purpose: Shared constants for the character display host front end
// Assumes: 20 MHz core clock (50 ns period)
// Notes: Counts of cycles are derived from times in ns
package char_lcd_pkg;

	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 50;
	localparam int EXEC_TIME_NS = 37000;
	localparam int EXEC_CYCLES =
		(EXEC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CLEAR_TIME_NS = 1520000;
	localparam int CLEAR_CYCLES =
		(CLEAR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ---------------------------------------------------------------
	// Memory layout
	// ---------------------------------------------------------------
	localparam int TEXT_DEPTH = 80;
	localparam int GLYPH_DEPTH = 64;
	localparam logic [6:0] LINE_LEN = 7'h28;
	localparam logic [6:0] LINE2_BASE = 7'h40;
	localparam logic [7:0] SPACE_CODE = 8'h20;
	localparam logic [7:0] CMD_CLEAR = 8'h01;

	// ---------------------------------------------------------------
	// Reset values of mode bits
	// ---------------------------------------------------------------
	localparam logic WIDE_BUS_RESET = 1'b1;
	localparam logic INC_RESET = 1'b1;
	localparam logic EXT_RESET = 1'b0;
	localparam logic DISP_ON_RESET = 1'b0;
	localparam logic TWO_LINE_RESET = 1'b0;

	// ---------------------------------------------------------------
	// Positions in the synchronised pin vector
	// ---------------------------------------------------------------
	localparam int PIN_RST_N = 13;
	localparam int PIN_STRAP = 12;
	localparam int PIN_THREE = 11;
	localparam int PIN_RS = 10;
	localparam int PIN_RW = 9;
	localparam int PIN_EN = 8;
	localparam int PIN_W = 14;

	// ---------------------------------------------------------------
	// Serial link
	// ---------------------------------------------------------------
	localparam int SER_CS_BIT = 5;
	localparam int SER_SID_BIT = 7;
	localparam logic [3:0] FRAME_BITS_4W = 4'h8;
	localparam logic [3:0] FRAME_BITS_3W = 4'h9;

endpackage : char_lcd_pkg

//--- host_bus_model.sv
// Purpose: Host processor model on the display front end pins
// Assumes: Core clock 50 ns; serial clock 125 ns, still between frames
// Notes: Lines nobody drives show the inverse of their last level
`timescale 1ns/10ps
module host_bus_model (
	// Clock
	input wire logic core_clk_i,
	// Device drive
	input wire logic [7:0] dev_data_i,
	input wire logic dev_oe_i,
	// Pins
	output logic [7:0] bus_o,
	output logic rs_o,
	output logic rw_o,
	output logic en_o
);
	logic [7:0] drv_reg;
	logic [7:0] last_reg;
	logic drv_on;
	logic nib;

	initial
	begin
		drv_reg = 8'h00;
		last_reg = 8'h00;
		drv_on = 1'b0;
		nib = 1'b0;
		rs_o = 1'b0;
		rw_o = 1'b1;
		en_o = 1'b0;
	end

	// ----------------------------------------
	// Wire level
	// ----------------------------------------
	// Remember only driven levels, so an idle line stays still
	always @(posedge core_clk_i)
		if (dev_oe_i || drv_on)
			last_reg <= bus_o;

	always_comb
	begin
		if (dev_oe_i)
			bus_o = dev_data_i;
		else if (drv_on)
			bus_o = drv_reg;
		else
			bus_o = ~last_reg;
	end

	// ----------------------------------------
	// Parallel strobe
	// ----------------------------------------
	task automatic par(input logic rs, input logic rw,
		input logic [7:0] d, output logic [7:0] q);
		@(negedge core_clk_i);
		rs_o = rs;
		rw_o = rw;
		drv_reg = d;
		drv_on = !rw;
		repeat (4) @(negedge core_clk_i);
		en_o = 1'b1;
		repeat (8) @(posedge core_clk_i);
		@(negedge core_clk_i);
		q = bus_o;
		en_o = 1'b0;
		repeat (5) @(negedge core_clk_i);
		drv_on = 1'b0;
	endtask : par

	task automatic acc(input logic rs, input logic rw,
		input logic [7:0] d, output logic [7:0] q);
		logic [7:0] h;
		logic [7:0] l;
		if (!nib)
			par(rs, rw, d, q);
		else
		begin
			// High nibble first, on lines 7..4
			par(rs, rw, {d[7:4], 4'h0}, h);
			par(rs, rw, {d[3:0], 4'h0}, l);
			q = {h[7:4], l[7:4]};
		end
	endtask : acc

	// Bounded poll; the bench timeout catches a stuck device
	task automatic idle();
		logic [7:0] s;
		int k;
		k = 0;
		do
		begin
			acc(1'b0, 1'b1, 8'h00, s);
			k++;
		end
		while (s[7] !== 1'b0 && k < 4000);
	endtask : idle

	// ----------------------------------------
	// Serial frame, MSB first
	// ----------------------------------------
	task automatic ser(input logic three, input logic rs,
		input logic [7:0] d);
		logic [8:0] f;
		f = {rs, d};
		rs_o = three ? 1'b0 : rs;
		drv_reg[5] = 1'b0;
		#40;
		for (int i = (three ? 8 : 7); i >= 0; i--)
		begin
			drv_reg[7] = f[i];
			#62.5;
			drv_reg[6] = 1'b1;
			#62.5;
			drv_reg[6] = 1'b0;
		end
		#40;
		drv_reg[5] = 1'b1;
		drv_reg[7] = ~f[0];
	endtask : ser
endmodule : host_bus_model

//--- char_lcd_host_interface_test.sv
// Purpose: Self-checking bench for the display host front end
// Assumes: Clear time shortened to 200 cycles
// Notes: Host model drives the pins; bench drives straps and scan
`timescale 1ns/10ps
module char_lcd_host_interface_test;
	logic clk;
	logic reset;
	logic rst_n;
	logic strap;
	logic three;
	logic scan_line;
	logic [3:0] scan_col;
	logic [3:0] scan_row;
	logic tall;
	logic [7:0] bus;
	logic [7:0] dout;
	logic oe;
	logic rs;
	logic rw;
	logic en;
	logic [4:0] pix;
	logic disp_on;
	logic two_line;
	logic busy;
	logic [7:0] q;
	int n_fail = 0;
	int n_tests = 0;
	int cycles = 0;

	char_lcd_host_interface #(.CLEAR_CYC(200)) i_dut (
		.core_clk_i(clk), .reset_i(reset), .serial_clk_i(bus[6]),
		.rst_n_i(rst_n), .interface_select_strap_i(strap),
		.three_wire_select_i(three), .register_select_i(rs),
		.read_write_i(rw), .enable_i(en), .parallel_data_lines_i(bus),
		.parallel_data_lines_o(dout), .parallel_data_lines_oe_o(oe),
		.scan_line_i(scan_line), .scan_col_i(scan_col),
		.scan_row_i(scan_row), .font_tall_i(tall),
		.scan_pixels_o(pix), .display_on_o(disp_on),
		.two_line_o(two_line), .internal_busy_indication_o(busy));

	host_bus_model i_host (
		.core_clk_i(clk), .dev_data_i(dout), .dev_oe_i(oe),
		.bus_o(bus), .rs_o(rs), .rw_o(rw), .en_o(en));

	// ----------------------------------------
	// Clock, timeout, helpers
	// ----------------------------------------
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 60000)
		begin
			n_fail++;
			end_sim();
		end
	end

	task automatic end_sim();
		$display("checks %0d, mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : end_sim

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			n_fail++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic cmd(input logic [7:0] c);
		logic [7:0] x;
		i_host.idle();
		i_host.acc(1'b0, 1'b0, c, x);
	endtask : cmd

	task automatic wr(input logic [7:0] d);
		logic [7:0] x;
		i_host.idle();
		i_host.acc(1'b1, 1'b0, d, x);
	endtask : wr

	task automatic rd(output logic [7:0] r);
		i_host.idle();
		i_host.acc(1'b1, 1'b1, 8'h00, r);
	endtask : rd

	task automatic st(output logic [7:0] r);
		i_host.idle();
		i_host.acc(1'b0, 1'b1, 8'h00, r);
	endtask : st

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset();
		i_host.acc(1'b0, 1'b0, 8'h85, q);
		chk({7'h00, busy}, 8'h01);
		@(negedge clk);
		rst_n = 1'b1;
		st(q);
		chk(q, 8'h00);
	endtask : t_reset

	task automatic t_text();
		cmd(8'hC0);
		st(q);
		chk(q, 8'h40);
		wr(8'h41);
		wr(8'h42);
		st(q);
		chk(q, 8'h42);
		cmd(8'hC0);
		rd(q);
		chk(q, 8'h41);
		rd(q);
		chk(q, 8'h42);
	endtask : t_text

	task automatic t_busy();
		cmd(8'h80);
		i_host.acc(1'b0, 1'b1, 8'h00, q);
		chk(q[7:0], 8'h80);
		i_host.acc(1'b0, 1'b0, 8'h85, q);
		st(q);
		chk(q, 8'h00);
	endtask : t_busy

	task automatic t_entry();
		cmd(8'h04);
		cmd(8'h8A);
		wr(8'h33);
		st(q);
		chk(q, 8'h09);
		cmd(8'h06);
		cmd(8'h14);
		st(q);
		chk(q, 8'h0A);
		cmd(8'h3C);
		cmd(8'h85);
		st(q);
		chk(q, 8'h0A);
		cmd(8'h38);
		cmd(8'h02);
		st(q);
		chk(q, 8'h00);
	endtask : t_entry

	task automatic t_glyph();
		cmd(8'h48);
		wr(8'hFF);
		cmd(8'hC3);
		wr(8'h09);
		cmd(8'h0C);
		cmd(8'h38);
		chk({6'h00, disp_on, two_line}, 8'h03);
		@(negedge clk);
		scan_line = 1'b1;
		scan_col = 4'h3;
		scan_row = 4'h0;
		repeat (3) @(negedge clk);
		chk({3'h0, pix}, 8'h1F);
		@(negedge clk);
		scan_line = 1'b0;
		scan_col = 4'hA;
		scan_row = 4'h8;
		repeat (3) @(negedge clk);
		chk({3'h0, pix}, 8'h00);
		@(negedge clk);
		tall = 1'b1;
		scan_row = 4'hA;
		repeat (3) @(negedge clk);
		chk({3'h0, pix}, 8'h00);
	endtask : t_glyph

	task automatic t_serial();
		i_host.idle();
		@(negedge clk);
		strap = 1'b0;
		i_host.drv_reg = 8'h3F;
		i_host.drv_on = 1'b1;
		repeat (10) @(negedge clk);
		i_host.ser(1'b0, 1'b0, 8'h90);
		repeat (800) @(negedge clk);
		i_host.ser(1'b0, 1'b1, 8'h55);
		repeat (800) @(negedge clk);
		three = 1'b1;
		i_host.ser(1'b1, 1'b1, 8'hAA);
		repeat (800) @(negedge clk);
		i_host.drv_on = 1'b0;
		strap = 1'b1;
		repeat (10) @(negedge clk);
		cmd(8'h90);
		rd(q);
		chk(q, 8'h55);
		rd(q);
		chk(q, 8'hAA);
	endtask : t_serial

	task automatic t_clear();
		cmd(8'h01);
		st(q);
		chk(q, 8'h00);
		cmd(8'hCF);
		rd(q);
		chk(q, 8'h20);
	endtask : t_clear

	task automatic t_nibble();
		cmd(8'h28);
		i_host.nib = 1'b1;
		cmd(8'h85);
		wr(8'h6C);
		cmd(8'h85);
		rd(q);
		chk(q, 8'h6C);
		st(q);
		chk(q, 8'h06);
	endtask : t_nibble

	initial
	begin
		reset = 1'b1;
		rst_n = 1'b0;
		strap = 1'b1;
		three = 1'b0;
		scan_line = 1'b0;
		scan_col = 4'h0;
		scan_row = 4'h0;
		tall = 1'b0;
		repeat (8) @(negedge clk);
		reset = 1'b0;
		t_reset();
		t_text();
		t_busy();
		t_entry();
		t_glyph();
		t_serial();
		t_clear();
		t_nibble();
		end_sim();
	end
endmodule : char_lcd_host_interface_test
